// ### rtl/adc_output_ctrl.sv
// output control of the pipelined converter: phase detect, hold, five stages,
// alignment, formatting, power modes and an APB status and interrupt block
// assumes pins are asynchronous to pclk and the sample clock is well below pclk/4
`timescale 1ns/1ps
`default_nettype none
module adc_output_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sample_clock_pos,
   input  wire logic        sample_clock_neg,
   input  wire logic [11:0] analog_in,
   input  wire logic        power_down_select,
   input  wire logic        output_enable_n,
   input  wire logic [1:0]  mode_level,
   output logic      [10:0] sample_word,
   output logic             range_exceeded_flag,
   output logic             data_valid_strobe,
   output logic             outputs_oe_n,
   output logic             stabilizer_on,
   output logic             irq
);
   localparam int STAGES  = adc_ctrl_pkg::STAGES;
   localparam int ALIGN_N = adc_ctrl_pkg::ALIGN_N;
   logic [1:0]                 clk_s;
   logic [15:0]                pin_s;
   logic signed [11:0]         ana_s;
   logic                       pd_s;
   logic                       oe_s;
   logic [1:0]                 mode_s;
   logic                       phase_w;
   logic                       phase_d_r;
   logic                       rise_w;
   logic                       fall_w;
   logic                       run_w;
   logic signed [11:0]         track_r;
   logic [10:0]                q_code;
   logic                       q_ovr;
   logic [10:0]                held_code_r;
   logic                       held_ovr_r;
   logic [10:0]                res_w [STAGES+1];
   logic [10:0]                acc_w [STAGES+1];
   logic                       flg_w [STAGES+1];
   logic [11:0]                align_r [ALIGN_N];
   logic                       twos_w;
   adc_ctrl_pkg::power_state_t pwr_r;
   adc_ctrl_pkg::power_state_t pwr_nxt;
   logic                       conv_en_r;
   logic [2:0]                 int_status_r;
   logic [2:0]                 int_en_r;
   logic [2:0]                 ev_w;
   logic [31:0]                count_r;
   logic [31:0]                rd_nxt;
   logic                       rd_err;
   logic                       wr_w;
   logic                       clr_w;

   // ==========================================================
   // pin synchronisers
   sync2 #(.W(2)) u_clk_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({sample_clock_pos, sample_clock_neg}),
      .q     (clk_s)
   );
   sync2 #(.W(16)) u_pin_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({analog_in, power_down_select, output_enable_n, mode_level}),
      .q     (pin_s)
   );
   assign ana_s  = pin_s[15:4];
   assign pd_s   = pin_s[3];
   assign oe_s   = pin_s[2];
   assign mode_s = pin_s[1:0];

   // ==========================================================
   // power state; nap and sleep stop the phase edges, so the pipeline freezes
   always_comb begin
      if (!pd_s && !oe_s) begin
         pwr_nxt = adc_ctrl_pkg::PWR_RUN;
      end else if (!pd_s) begin
         pwr_nxt = adc_ctrl_pkg::PWR_HIZ;
      end else if (!oe_s) begin
         pwr_nxt = adc_ctrl_pkg::PWR_NAP;
      end else begin
         pwr_nxt = adc_ctrl_pkg::PWR_SLEEP;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_r <= adc_ctrl_pkg::PWR_SLEEP;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end
   assign run_w = conv_en_r && !pwr_r[1];

   // ==========================================================
   // phase detect and edge enables
   assign phase_w = clk_s[1] && !clk_s[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_d_r <= 1'b0;
      end else if (run_w) begin
         // frozen while halted, so rise and fall always alternate in the stages
         phase_d_r <= phase_w;
      end
   end
   assign rise_w = run_w && phase_w && !phase_d_r;
   assign fall_w = run_w && !phase_w && phase_d_r;

   // ==========================================================
   // track and hold with range check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         track_r <= '0;
      end else if (!phase_w) begin
         track_r <= ana_s;
      end
   end
   always_comb begin
      if (track_r > adc_ctrl_pkg::ANA_MAX) begin
         q_code = adc_ctrl_pkg::CODE_MAX;
         q_ovr  = 1'b1;
      end else if (track_r < adc_ctrl_pkg::ANA_MIN) begin
         q_code = adc_ctrl_pkg::CODE_MIN;
         q_ovr  = 1'b1;
      end else begin
         q_code = {~track_r[10], track_r[9:0]};
         q_ovr  = 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_code_r <= adc_ctrl_pkg::OFFSET_ZERO;
         held_ovr_r  <= 1'b0;
      end else if (rise_w) begin
         held_code_r <= q_code;
         held_ovr_r  <= q_ovr;
      end
   end

   // ==========================================================
   // five stages on alternating edges, then alignment to the output edge
   assign res_w[0] = held_code_r;
   assign acc_w[0] = '0;
   assign flg_w[0] = held_ovr_r;
   for (genvar k = 0; k < STAGES; k++) begin : g_stage
      conv_stage #(
         .W   (adc_ctrl_pkg::WORD_W),
         .DIG ((k == STAGES-1) ? 3 : 2),
         .POS ((k == STAGES-1) ? 0 : 9 - 2*k)
      ) u_stage (
         .clk      (pclk),
         .rst_n    (presetn),
         .load     ((k % 2 == 0) ? fall_w : rise_w),
         .res_in   (res_w[k]),
         .acc_in   (acc_w[k]),
         .flag_in  (flg_w[k]),
         .res_out  (res_w[k+1]),
         .acc_out  (acc_w[k+1]),
         .flag_out (flg_w[k+1])
      );
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         align_r[0] <= {1'b0, adc_ctrl_pkg::OFFSET_ZERO};
         align_r[1] <= {1'b0, adc_ctrl_pkg::OFFSET_ZERO};
      end else if (rise_w) begin
         align_r[0] <= {flg_w[STAGES], acc_w[STAGES]};
         align_r[1] <= align_r[0];
      end
   end

   // ==========================================================
   // output word, flag and strobe share one update edge
   assign twos_w = mode_s[1];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_word         <= '0;
         range_exceeded_flag <= 1'b0;
         data_valid_strobe   <= 1'b0;
      end else if (rise_w) begin
         sample_word         <= {align_r[1][10] ^ twos_w, align_r[1][9:0]};
         range_exceeded_flag <= align_r[1][11];
         data_valid_strobe   <= 1'b1;
      end else if (fall_w || !run_w) begin
         data_valid_strobe   <= 1'b0; // falls mid-word, where the receiver latches
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outputs_oe_n  <= 1'b1;
         stabilizer_on <= 1'b0;
      end else begin
         outputs_oe_n  <= (pwr_r != adc_ctrl_pkg::PWR_RUN);
         stabilizer_on <= (mode_s == adc_ctrl_pkg::MODE_THIRD) ||
                          (mode_s == adc_ctrl_pkg::MODE_TWO_THIRD);
      end
   end

   // ==========================================================
   // APB slave: zero wait states, pready in the first access cycle
   assign wr_w  = psel && penable && pready && pwrite;
   assign clr_w = wr_w && (paddr == adc_ctrl_pkg::ADDR_INT_CLEAR);
   always_comb begin
      rd_nxt = '0;
      rd_err = 1'b0;
      if (paddr == adc_ctrl_pkg::ADDR_CTRL) begin
         rd_nxt[adc_ctrl_pkg::CTRL_CONV_EN] = conv_en_r;
      end else if (paddr == adc_ctrl_pkg::ADDR_INT_STATUS) begin
         rd_nxt[2:0] = int_status_r;
      end else if (paddr == adc_ctrl_pkg::ADDR_INT_CLEAR) begin
         rd_nxt = '0;
      end else if (paddr == adc_ctrl_pkg::ADDR_INT_ENABLE) begin
         rd_nxt[2:0] = int_en_r;
      end else if (paddr == adc_ctrl_pkg::ADDR_STATE) begin
         rd_nxt[10:0] = sample_word;
         rd_nxt[adc_ctrl_pkg::ST_FLAG] = range_exceeded_flag;
         rd_nxt[adc_ctrl_pkg::ST_PWR +: 2] = pwr_r;
         rd_nxt[adc_ctrl_pkg::ST_TWOS] = twos_w;
         rd_nxt[adc_ctrl_pkg::ST_STAB] = stabilizer_on;
      end else if (paddr == adc_ctrl_pkg::ADDR_COUNT) begin
         rd_nxt = count_r;
      end else begin
         rd_err = 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && rd_err;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_en_r <= adc_ctrl_pkg::CTRL_RST;
         int_en_r  <= adc_ctrl_pkg::INT_EN_RST;
      end else if (wr_w && paddr == adc_ctrl_pkg::ADDR_CTRL) begin
         conv_en_r <= pwdata[adc_ctrl_pkg::CTRL_CONV_EN];
      end else if (wr_w && paddr == adc_ctrl_pkg::ADDR_INT_ENABLE) begin
         int_en_r  <= pwdata[2:0];
      end
   end

   // ==========================================================
   // interrupts: a new event beats a clear in the same cycle
   assign ev_w = {pwr_nxt != pwr_r, rise_w && align_r[1][11], rise_w};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_r <= '0;
         irq          <= 1'b0;
         count_r      <= '0;
      end else begin
         int_status_r <= (int_status_r & ~(clr_w ? pwdata[2:0] : 3'h0)) | ev_w;
         irq          <= |(int_status_r & int_en_r);
         if (rise_w) begin
            count_r <= count_r + 32'h1;
         end
      end
   end

   // ==========================================================
   // checks; shadow holds each held code until its five cycles are up
   logic [11:0] shd_r [STAGES];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < STAGES; i++) begin
            shd_r[i] <= {1'b0, adc_ctrl_pkg::OFFSET_ZERO};
         end
      end else if (rise_w) begin
         shd_r[0] <= {q_ovr, q_code};
         for (int i = 1; i < STAGES; i++) begin
            shd_r[i] <= shd_r[i-1];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   phase_rise_a: assert property (rise_w |-> clk_s == 2'b10 && !phase_d_r)
      else $error("rise taken without positive phase");
   track_a: assert property (!phase_w |=> track_r == $past(ana_s))
      else $error("input not tracked in low phase");
   hold_a: assert property (phase_w && !rise_w |=> $stable(held_code_r))
      else $error("held sample moved in high phase");
   latency_a: assert property (rise_w && count_r >= STAGES |-> align_r[1] == shd_r[STAGES-1])
      else $error("result not five cycles after its sample");
   stage1_a: assert property (fall_w |=> acc_w[1][10:9] == $past(held_code_r[10:9]))
      else $error("first stage missed held sample");
   alternate_a: assert property (fall_w |=> $stable(acc_w[2]) && $stable(acc_w[4]))
      else $error("even stage loaded on falling phase");
   merge_a: assert property (rise_w && !twos_w |=> sample_word == $past(align_r[1][10:0]))
      else $error("merged word differs from offset output");
   drive_a: assert property (pwr_r == adc_ctrl_pkg::PWR_RUN |=> !outputs_oe_n)
      else $error("outputs not driven in normal mode");
   hiz_run_a: assert property (pwr_r == adc_ctrl_pkg::PWR_HIZ && rise_w |=> outputs_oe_n && data_valid_strobe)
      else $error("converting with disabled outputs failed");
   nap_a: assert property (pwr_r == adc_ctrl_pkg::PWR_NAP |-> !rise_w ##1 outputs_oe_n)
      else $error("nap still converting or driving");
   sleep_a: assert property (pwr_r == adc_ctrl_pkg::PWR_SLEEP |=> $stable(sample_word) && outputs_oe_n)
      else $error("sleep still converting or driving");
   twos_fmt_a: assert property (rise_w && twos_w |=> sample_word == {~$past(align_r[1][10]), $past(align_r[1][9:0])})
      else $error("two's complement format wrong");
   zero_code_a: assert property (rise_w && twos_w && align_r[1][10:0] == adc_ctrl_pkg::OFFSET_ZERO |=> sample_word == '0)
      else $error("zero not all zeros in two's complement");
   range_flag_a: assert property (rise_w |=> range_exceeded_flag == $past(align_r[1][11]))
      else $error("range flag not carried with its word");
   word_strobe_a: assert property ($changed(sample_word) |-> $rose(data_valid_strobe))
      else $error("word changed apart from strobe");
   min_code_a: assert property (track_r < adc_ctrl_pkg::ANA_MIN |-> q_code == '0 && q_ovr)
      else $error("most negative input not all zeros");

   twos_cov: cover property (rise_w && twos_w);
   flag_cov: cover property (rise_w && align_r[1][11]);
   nap_cov:  cover property (pwr_r == adc_ctrl_pkg::PWR_NAP);
endmodule
`default_nettype wire

// ### rtl/adc_ctrl_pkg.sv
// constants, register map and types of the pipelined converter output control
// assumes a single 40 MHz pclk domain and APB access to the status registers
//
// How it works
// - sample clock phase is high when positive input exceeds negative, else low.
// - input is tracked while phase low and frozen at its rising transition.
// - each sample's result reaches the output word five sample cycles later.
// - first stage takes the held sample in high phase, passes residue at fall.
// - neighbouring stages load on opposite phase edges, odd and even alternate.
// - partial digits of all five stages travel aligned and merge into one word.
// - power-down low, output enable low: convert and drive the outputs.
// - power-down low, output enable high: keep converting, outputs high impedance.
// - power-down high, output enable low: nap, outputs high impedance.
// - both high: sleep, outputs high impedance.
// - mode level picks number format and stabilizer as the four-level table.
// - eleven-bit word, top bit carries the result's most significant bit.
// - range flag high whenever the input left the convertible range.
// - two's complement: zero reads all zeros, just below zero all ones.
package adc_ctrl_pkg;
   // ==========================================================
   // widths and pipeline shape
   localparam int WORD_W    = 11;
   localparam int ANA_W     = 12;
   localparam int STAGES    = 5;
   localparam int ALIGN_N   = 2;
   localparam int INT_W     = 3;
   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_CLEAR  = 8'h08;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'h0c;
   localparam logic [7:0] ADDR_STATE      = 8'h10;
   localparam logic [7:0] ADDR_COUNT      = 8'h14;
   localparam int         CTRL_CONV_EN    = 0;
   localparam logic       CTRL_RST        = 1'h1;
   localparam logic [2:0] INT_EN_RST      = 3'h0;
   localparam int         EV_WORD         = 0;
   localparam int         EV_RANGE        = 1;
   localparam int         EV_POWER        = 2;
   localparam int         ST_FLAG         = 11;
   localparam int         ST_PWR          = 12;
   localparam int         ST_TWOS         = 14;
   localparam int         ST_STAB         = 15;
   // ==========================================================
   // codes
   localparam logic [1:0]        MODE_GND       = 2'h0;
   localparam logic [1:0]        MODE_THIRD     = 2'h1;
   localparam logic [1:0]        MODE_TWO_THIRD = 2'h2;
   localparam logic [1:0]        MODE_VDD       = 2'h3;
   localparam logic [10:0]       OFFSET_ZERO    = 11'h400;
   localparam logic [10:0]       CODE_MAX       = 11'h7ff;
   localparam logic [10:0]       CODE_MIN       = 11'h000;
   localparam logic signed [11:0] ANA_MAX       = 12'sh3ff;
   localparam logic signed [11:0] ANA_MIN       = 12'shc00;
   typedef enum logic [1:0] {
      PWR_RUN   = 2'b00,
      PWR_HIZ   = 2'b01,
      PWR_NAP   = 2'b10,
      PWR_SLEEP = 2'b11
   } power_state_t;
endpackage

// ### rtl/sync2.sv
// two flip-flop synchroniser for pins from outside the pclk domain
// assumes each bit is a level; multi-bit groups must be quasi-static
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // ==========================================================
   // first stage is read by the second only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ### rtl/conv_stage.sv
// one conversion stage: resolves DIG digits of its residue and passes the rest
// assumes load is a one-cycle enable on the stage's own phase edge
`timescale 1ns/1ps
`default_nettype none
module conv_stage #(
   parameter int W   = 11,
   parameter int DIG = 2,
   parameter int POS = 9
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] res_in,
   input  wire logic [W-1:0] acc_in,
   input  wire logic         flag_in,
   output logic      [W-1:0] res_out,
   output logic      [W-1:0] acc_out,
   output logic              flag_out
);
   logic [W-1:0] digit_w;

   assign digit_w = W'(res_in[W-1 -: DIG]) << POS;

   // ==========================================================
   // digits ride with their sample so later stages stay aligned
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_out  <= '0;
         acc_out  <= '0;
         flag_out <= 1'b0;
      end else if (load) begin
         res_out  <= res_in << DIG;
         acc_out  <= acc_in | digit_w;
         flag_out <= flag_in;
      end
   end
endmodule
`default_nettype wire

// ### testbench/capture_model.sv
// capture logic on the far side: latches word and flag on the strobe's fall
// assumes word, flag and strobe share one output enable, low while driven
`timescale 1ns/1ps
`default_nettype none
module capture_model (
   input  wire logic        data_valid_strobe,
   input  wire logic [10:0] sample_word,
   input  wire logic        range_exceeded_flag,
   input  wire logic        outputs_oe_n,
   output logic      [10:0] cap_word,
   output logic             cap_flag,
   output logic      [15:0] cap_count
);
   // ==========================================================
   // pins and capture
   // a released line shows the inverse of its last value, never a kind default
   logic [10:0] word_pin;
   logic        flag_pin;
   assign word_pin = outputs_oe_n ? ~sample_word : sample_word;
   assign flag_pin = outputs_oe_n ? ~range_exceeded_flag : range_exceeded_flag;
   initial cap_count = 16'h0000;
   always @(negedge data_valid_strobe) begin
      if (outputs_oe_n === 1'b0) begin
         cap_word  <= word_pin;
         cap_flag  <= flag_pin;
         cap_count <= cap_count + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench: apb tasks, free sample clock, capture model
// assumes the design answers apb in one access cycle and syncs its pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ==========================================================
   // signals
   logic        pclk, presetn, psel, penable, pwrite, err, sample_clock_pos;
   logic        power_down_select, output_enable_n, pready, pslverr;
   logic        range_exceeded_flag, data_valid_strobe, outputs_oe_n;
   logic        stabilizer_on, irq, cap_flag;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, c1;
   logic [11:0] analog_in;
   logic [1:0]  mode_level;
   logic [10:0] sample_word, cap_word;
   logic [15:0] cap_count;
   int          miscompares, checks, k;
   int          vals[5] = '{0, -1, 2000, -2000, 1023};
   adc_output_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_clock_pos(sample_clock_pos),
      .sample_clock_neg(~sample_clock_pos), .analog_in(analog_in),
      .power_down_select(power_down_select), .output_enable_n(output_enable_n),
      .mode_level(mode_level), .sample_word(sample_word),
      .range_exceeded_flag(range_exceeded_flag), .data_valid_strobe(data_valid_strobe),
      .outputs_oe_n(outputs_oe_n), .stabilizer_on(stabilizer_on), .irq(irq));
   capture_model far (.data_valid_strobe(data_valid_strobe), .sample_word(sample_word),
      .range_exceeded_flag(range_exceeded_flag), .outputs_oe_n(outputs_oe_n),
      .cap_word(cap_word), .cap_flag(cap_flag), .cap_count(cap_count));
   // ==========================================================
   // clocks; the 200 ns sample clock is offset so its edges never meet pclk's
   always #12.5 pclk = ~pclk;
   initial begin
      sample_clock_pos = 1'b0;
      #7;
      forever #100 sample_clock_pos = ~sample_clock_pos;
   end
   // ==========================================================
   // tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no wait limit here: only the watchdog ends a hung transfer
      while (pready !== 1'b1) @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic caps(input int n);
      int t;
      t = cap_count + n;
      while (cap_count < t) @(posedge pclk);
   endtask
   task automatic apply(input int v);
      @(posedge pclk);
      analog_in <= 12'(v);
      caps(8);
   endtask
   function automatic logic [10:0] fmt(input int v, input logic twos);
      int c;
      c = (v > 1023) ? 1023 : ((v < -1024) ? -1024 : v);
      return 11'(c + 1024) ^ (twos ? 11'h400 : 11'h000);
   endfunction
   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // watchdog, several times the expected run
   initial begin
      #400000;
      miscompares++;
      complete_run;
   end
   // ==========================================================
   // tests
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {power_down_select, output_enable_n, mode_level, analog_in} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(adc_ctrl_pkg::ADDR_CTRL, 1'b0, 32'h0);
      check("ctrl", rd, 32'h1);
      apb(adc_ctrl_pkg::ADDR_INT_ENABLE, 1'b0, 32'h0);
      check("int_en", rd, 32'h0);
      apb(8'h20, 1'b1, 32'hffff_ffff);
      check("wr_err", 32'(err), 32'h1);
      apb(8'h20, 1'b0, 32'h0);
      check("rd_err", {rd[30:0], err}, 32'h1);
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         mode_level <= 2'(m);
         for (int i = 0; i < 5; i++) begin
            apply(vals[i]);
            check("word", 32'(cap_word), 32'(fmt(vals[i], m[1])));
            check("flag", 32'(cap_flag), 32'(vals[i] > 1023 || vals[i] < -1024));
         end
         check("stab", 32'(stabilizer_on), 32'(m == 1 || m == 2));
         apb(adc_ctrl_pkg::ADDR_STATE, 1'b0, 32'h0);
         check("fmt", 32'(rd[15:14]), 32'({m == 1 || m == 2, m[1]}));
      end
      $display("test formats done");
      apply(100);
      @(posedge sample_clock_pos);
      repeat (3) @(posedge pclk);
      analog_in <= 12'(-300);
      k = cap_count;
      caps(k + 6 - cap_count);
      check("old", 32'(cap_word), 32'(fmt(100, 1'b1)));
      caps(1);
      check("new", 32'(cap_word), 32'(fmt(-300, 1'b1)));
      $display("test latency done");
      for (int i = 0; i < 4; i++) begin
         {power_down_select, output_enable_n} <= 2'(i);
         repeat (4) @(posedge sample_clock_pos);
         @(posedge pclk);
         check("oe_n", 32'(outputs_oe_n), 32'(i != 0));
         apb(adc_ctrl_pkg::ADDR_STATE, 1'b0, 32'h0);
         check("pwr", 32'(rd[13:12]), 32'(i));
         apb(adc_ctrl_pkg::ADDR_COUNT, 1'b0, 32'h0);
         c1 = rd;
         repeat (4) @(posedge sample_clock_pos);
         apb(adc_ctrl_pkg::ADDR_COUNT, 1'b0, 32'h0);
         check("conv", 32'(rd != c1), 32'(i < 2));
      end
      {power_down_select, output_enable_n} <= 2'h0;
      $display("test power done");
      apb(adc_ctrl_pkg::ADDR_CTRL, 1'b1, 32'h0);
      repeat (4) @(posedge sample_clock_pos);
      apb(adc_ctrl_pkg::ADDR_INT_CLEAR, 1'b1, 32'h7);
      apb(adc_ctrl_pkg::ADDR_INT_ENABLE, 1'b1, 32'h1);
      apb(adc_ctrl_pkg::ADDR_INT_STATUS, 1'b0, 32'h0);
      check("sts_clr", rd, 32'h0);
      check("irq_lo", 32'(irq), 32'h0);
      apb(adc_ctrl_pkg::ADDR_CTRL, 1'b1, 32'h1);
      caps(3);
      check("irq_hi", 32'(irq), 32'h1);
      apb(adc_ctrl_pkg::ADDR_INT_ENABLE, 1'b1, 32'h0);
      repeat (3) @(posedge pclk);
      check("irq_mask", 32'(irq), 32'h0);
      apb(adc_ctrl_pkg::ADDR_INT_STATUS, 1'b0, 32'h0);
      check("sts_word", 32'(rd[0]), 32'h1);
      $display("test interrupt done");
      complete_run;
   end
endmodule
`default_nettype wire
